// ### common/sbc_pkg.sv
// Purpose: shared constants and helpers for the backplane bus cycle ends.
// Assumes: both ends run on the one system clock made by the permanent master.
// Notes: line levels are resolved in sbc_bus_if; ends only drive and enable.
package sbc_pkg;

  // ************************************************************
  // Status word and driver disable layout
  // ************************************************************
  localparam int ST_MEMR = 0;
  localparam int ST_M1 = 1;
  localparam int ST_WO_N = 2;
  localparam int ST_OUT = 3;
  localparam int ST_INP = 4;
  localparam int ST_INTA = 5;
  localparam int ST_HLTA = 6;
  localparam int ST_XTRQ_N = 7;
  localparam int DS_ADDR = 0;
  localparam int DS_DOUT = 1;
  localparam int DS_STAT = 2;
  localparam int DS_CTRL = 3;

  // ************************************************************
  // Timing, sizes and fixed values
  // ************************************************************
  localparam int CLK_NS = 50;
  localparam int STRB_NS = 150;
  localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEM_AW = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 26;
  localparam logic [7:0] VEC_BASE = 8'hC7;
  localparam logic [7:0] BUS_IDLE = 8'hFF;

  typedef enum logic [2:0] {
    CMD_MRD = 3'h0,
    CMD_FETCH = 3'h1,
    CMD_MWR = 3'h2,
    CMD_OUT = 3'h3,
    CMD_IN = 3'h4,
    CMD_INTA = 3'h5,
    CMD_HALT = 3'h6
  } sbc_cmd_t;

  // Status word for a cycle type; unused bits stay inactive
  function automatic logic [7:0] sbc_status(input sbc_cmd_t c, input logic w);
    logic [7:0] s;
    s = 8'h00;
    s[ST_WO_N] = 1'b1;
    s[ST_XTRQ_N] = ~w;
    case (c)
      CMD_MRD: s[ST_MEMR] = 1'b1;
      CMD_FETCH: begin
        s[ST_MEMR] = 1'b1;
        s[ST_M1] = 1'b1;
      end
      CMD_MWR: s[ST_WO_N] = 1'b0;
      CMD_OUT: begin
        s[ST_WO_N] = 1'b0;
        s[ST_OUT] = 1'b1;
      end
      CMD_IN: s[ST_INP] = 1'b1;
      CMD_INTA: s[ST_INTA] = 1'b1;
      CMD_HALT: s[ST_HLTA] = 1'b1;
      default: s[ST_HLTA] = 1'b0;
    endcase
    return s;
  endfunction

  // Lowest set index wins
  function automatic logic [2:0] sbc_prio(input logic [7:0] p);
    logic [2:0] i;
    i = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (p[k]) begin
        i = 3'(k);
      end
    end
    return i;
  endfunction

endpackage

// ### common/sbc_bus_if.sv
// Purpose: backplane lines between master end and slave end.
// Assumes: open-collector lines pull low while any enable is high.
// Notes: undriven three-state lines read as pulled high, except sync and dbin, which read low.
interface sbc_bus_if;
  import sbc_pkg::*;

  // Master drives
  logic [15:0] m_addr;
  logic [7:0] m_stat;
  logic m_addr_oe, m_stat_oe, m_ctl_oe;
  logic m_sync, m_stval_n, m_dbin, m_wr_n, m_phlda;
  logic [7:0] m_do, m_di;
  logic m_do_oe, m_di_oe;
  // Slave drives
  logic [7:0] s_do, s_di;
  logic s_do_oe, s_di_oe;
  logic s_rdy_oe, s_int_oe, s_nmi_oe, s_sixtn_oe, s_hold_oe;
  logic [3:0] s_dma_oe, s_dsb_oe;
  // Resolved line levels
  logic [15:0] addr;
  logic [7:0] stat, do_b, di_b;
  logic sync, stval_n, dbin, wr_n, phlda;
  logic rdy, int_n, nmi_n, sixtn_n, hold_n;
  logic [3:0] dma_n, dsb_n;

  assign addr = m_addr_oe ? m_addr : {2{BUS_IDLE}};
  assign stat = m_stat_oe ? m_stat : BUS_IDLE;
  assign sync = m_ctl_oe & m_sync;
  assign stval_n = ~m_ctl_oe | m_stval_n;
  assign dbin = m_ctl_oe & m_dbin;
  assign wr_n = ~m_ctl_oe | m_wr_n;
  assign phlda = m_phlda;
  assign do_b = m_do_oe ? m_do : (s_do_oe ? s_do : BUS_IDLE);
  assign di_b = m_di_oe ? m_di : (s_di_oe ? s_di : BUS_IDLE);
  assign rdy = ~s_rdy_oe;
  assign int_n = ~s_int_oe;
  assign nmi_n = ~s_nmi_oe;
  assign sixtn_n = ~s_sixtn_oe;
  assign hold_n = ~s_hold_oe;
  assign dma_n = ~s_dma_oe;
  assign dsb_n = ~s_dsb_oe;

  modport master (
    output m_addr, m_stat, m_addr_oe, m_stat_oe, m_ctl_oe, m_sync, m_stval_n,
    output m_dbin, m_wr_n, m_phlda, m_do, m_di, m_do_oe, m_di_oe,
    input do_b, di_b, rdy, int_n, nmi_n, sixtn_n, hold_n, dma_n, dsb_n
  );
  modport slave (
    output s_do, s_di, s_do_oe, s_di_oe, s_rdy_oe, s_int_oe, s_nmi_oe,
    output s_sixtn_oe, s_hold_oe, s_dma_oe, s_dsb_oe,
    input addr, stat, sync, stval_n, dbin, wr_n, phlda, do_b, di_b
  );
endinterface

// ### src/sbc_master.sv
// Purpose: permanent master end, runs bus cycles for a local requester.
// Assumes: mclk_in is the system clock that the whole bus times from.
// Notes: one request at a time; answer pulses once per finished cycle.
module sbc_master
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Cycle requests
  input wire logic req_valid_in,
  input wire sbc_cmd_t req_cmd_in,
  input wire logic req_word_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_ready_out,
  // Cycle answers
  output logic rsp_valid_out,
  output logic [15:0] rsp_rdata_out,
  output logic rsp_word_out,
  // Interrupt, hold and front panel control
  input wire logic int_en_in,
  input wire logic hold_en_in,
  input wire logic nmi_clr_in,
  input wire logic xrdy_in,
  output logic int_pend_out,
  output logic nmi_flag_out,
  output logic hold_ack_out,
  output logic [3:0] dma_win_out,
  // Backplane
  sbc_bus_if.master bus
);

  // ************************************************************
  // Cycle sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_T1 = 5'h02,
    M_T2 = 5'h04,
    M_T3 = 5'h08,
    M_HOLD = 5'h10
  } sbc_mst_t;

  sbc_mst_t st_q, st_d;
  logic rdy_q, int_q, hold_q, sixtn_q, nmi_q, nmi_old_q;
  logic xr1_q, xr2_q;
  logic [3:0] dma_q, dsb_q;
  sbc_cmd_t cmd_q;
  logic word_q;
  logic [1:0] cnt_q;
  logic [15:0] addr_q, wdat_q;
  logic [7:0] stat_q;
  logic sync_q, stval_n_q, dbin_q, wr_n_q, phlda_q;
  logic do_oe_q, di_oe_q, a_oe_q, s_oe_q, c_oe_q;
  logic is_rd, is_wr, grant, take, go;

  assign is_rd = cmd_q inside {CMD_MRD, CMD_FETCH, CMD_IN, CMD_INTA};
  assign is_wr = cmd_q inside {CMD_MWR, CMD_OUT};
  // A pending hold beats a new request only when not masked
  assign grant = hold_q && hold_en_in;
  assign take = (st_q == M_IDLE) && req_valid_in && req_ready_out && !grant;
  // Strobe stands its least time, then stretches while either ready is low
  assign go = (cnt_q >= 2'(STRB_CYC - 1)) && rdy_q && xr2_q;

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      M_IDLE: begin
        if (grant) begin
          st_d = M_HOLD;
        end else if (take) begin
          st_d = M_T1;
        end
      end
      M_T1: st_d = M_T2;
      M_T2: begin
        if (go) begin
          st_d = M_T3;
        end
      end
      M_T3: st_d = M_IDLE;
      M_HOLD: begin
        if (!hold_q) begin
          st_d = M_IDLE;
        end
      end
      default: st_d = M_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_q <= M_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Input sampling
  // ************************************************************
  // Bus inputs come from same-clock logic: one register, decisions per edge
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rdy_q <= 1'b1;
      int_q <= 1'b0;
      hold_q <= 1'b0;
      sixtn_q <= 1'b0;
      nmi_q <= 1'b0;
      nmi_old_q <= 1'b0;
      dma_q <= 4'h0;
      dsb_q <= 4'h0;
    end else begin
      rdy_q <= bus.rdy;
      int_q <= ~bus.int_n;
      hold_q <= ~bus.hold_n;
      sixtn_q <= ~bus.sixtn_n;
      nmi_q <= ~bus.nmi_n;
      nmi_old_q <= nmi_q;
      dma_q <= ~bus.dma_n;
      dsb_q <= ~bus.dsb_n;
    end
  end

  // Front panel ready arrives from a pin, so it is synchronised first
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      xr1_q <= 1'b1;
      xr2_q <= 1'b1;
    end else begin
      xr1_q <= xrdy_in;
      xr2_q <= xr1_q;
    end
  end

  // ************************************************************
  // Interrupt inputs
  // ************************************************************
  // Level request, seen only while software enables it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      int_pend_out <= 1'b0;
    end else begin
      int_pend_out <= int_q && int_en_in;
    end
  end

  // Falling line edge sets a sticky flag; a new edge beats the clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      nmi_flag_out <= 1'b0;
    end else if (nmi_q && !nmi_old_q) begin
      nmi_flag_out <= 1'b1;
    end else if (nmi_clr_in) begin
      nmi_flag_out <= 1'b0;
    end
  end

  // ************************************************************
  // Request capture and cycle status
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cmd_q <= CMD_HALT;
      word_q <= 1'b0;
      addr_q <= 16'h0000;
      wdat_q <= 16'h0000;
      stat_q <= 8'h00;
    end else if (take) begin
      cmd_q <= req_cmd_in;
      word_q <= req_word_in;
      addr_q <= req_addr_in;
      wdat_q <= req_wdata_in;
      stat_q <= sbc_status(req_cmd_in, req_word_in);
    end
  end

  // Accepting only in idle keeps one cycle on the bus at a time
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (st_d == M_IDLE);
    end
  end

  // Strobe length counter
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_q <= 2'h0;
    end else if (st_q != M_T2) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // ************************************************************
  // Control outputs
  // ************************************************************
  // Sync and status valid together mark the one safe sampling cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sync_q <= 1'b0;
      stval_n_q <= 1'b1;
      dbin_q <= 1'b0;
      wr_n_q <= 1'b1;
      phlda_q <= 1'b0;
    end else begin
      sync_q <= (st_d == M_T1);
      stval_n_q <= (st_d != M_T1);
      dbin_q <= (st_d == M_T2) && is_rd;
      wr_n_q <= !((st_d == M_T2) && is_wr);
      phlda_q <= (st_d == M_HOLD);
    end
  end

  // Data out only on writes; the word case gangs DI as the high byte
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      do_oe_q <= 1'b0;
      di_oe_q <= 1'b0;
    end else begin
      do_oe_q <= (st_d == M_T2) && is_wr && !dsb_q[DS_DOUT];
      di_oe_q <= (st_d == M_T2) && is_wr && word_q && !dsb_q[DS_DOUT];
    end
  end

  // Driver groups released when a temporary master disables them
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      a_oe_q <= 1'b1;
      s_oe_q <= 1'b1;
      c_oe_q <= 1'b1;
    end else begin
      a_oe_q <= !dsb_q[DS_ADDR];
      s_oe_q <= !dsb_q[DS_STAT];
      c_oe_q <= !dsb_q[DS_CTRL];
    end
  end

  // ************************************************************
  // Answers
  // ************************************************************
  // Read data taken at the edge that closes the strobe
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
      rsp_word_out <= 1'b0;
    end else begin
      rsp_valid_out <= (st_q == M_T2) && go;
      if ((st_q == M_T2) && go) begin
        rsp_word_out <= word_q && sixtn_q;
        if (is_rd && word_q && sixtn_q) begin
          rsp_rdata_out <= {bus.di_b, bus.do_b};
        end else if (is_rd) begin
          rsp_rdata_out <= {8'h00, bus.di_b};
        end
      end
    end
  end

  // Arbitration result and grant visible to local logic
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      hold_ack_out <= 1'b0;
      dma_win_out <= 4'h0;
    end else begin
      hold_ack_out <= phlda_q;
      dma_win_out <= dma_q;
    end
  end

  // Bus lines straight from their flops
  assign bus.m_addr = addr_q;
  assign bus.m_stat = stat_q;
  assign bus.m_addr_oe = a_oe_q;
  assign bus.m_stat_oe = s_oe_q;
  assign bus.m_ctl_oe = c_oe_q;
  assign bus.m_sync = sync_q;
  assign bus.m_stval_n = stval_n_q;
  assign bus.m_dbin = dbin_q;
  assign bus.m_wr_n = wr_n_q;
  assign bus.m_phlda = phlda_q;
  assign bus.m_do = wdat_q[7:0];
  assign bus.m_di = wdat_q[15:8];
  assign bus.m_do_oe = do_oe_q;
  assign bus.m_di_oe = di_oe_q;

endmodule

// ### src/sbc_slave.sv
// Purpose: memory, I/O and interrupt controller slave with a write buffer.
// Assumes: bus timing comes from the master's system clock.
// Notes: reads see memory, not writes still waiting in the buffer.
module sbc_fifo
  import sbc_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module sbc_slave
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Buffer drain and I/O port
  input wire logic drain_stall_in,
  input wire logic [7:0] io_rdata_in,
  output logic io_wr_valid_out,
  output logic [7:0] io_wr_addr_out,
  output logic [15:0] io_wr_data_out,
  // Interrupt controller
  input wire logic [7:0] vi_n_in,
  input wire logic [7:0] vi_mask_in,
  input wire logic nmi_req_in,
  // Temporary master request
  input wire logic dma_req_in,
  input wire logic [3:0] dma_prio_in,
  // Observed cycle
  output logic [7:0] cyc_stat_out,
  // Backplane
  sbc_bus_if.slave bus
);
  logic sync_q, stval_q, dbin_q, wr_q, wr_old_q, phlda_q;
  logic [7:0] stat_q, do_q, di_q, vi1_q, vi2_q, pend;
  logic [15:0] addr_q, cyc_addr_q;
  logic mem_rd, mem_wr, io_out, io_in, inta, word;
  logic pend_q, f_rdy, f_vld;
  logic [FIFO_W-1:0] pend_data_q, f_data;
  logic [7:0] mem_q [2**MEM_AW];
  logic [MEM_AW-1:0] a, ev, od, da;
  logic s_do_oe_q, s_di_oe_q, rdy_oe_q, int_oe_q, nmi_oe_q, sixtn_oe_q;
  logic hold_oe_q;
  logic [7:0] s_do_q, s_di_q;
  logic [3:0] dma_oe_q, dsb_oe_q;

  // Word memory cycle decode, used on the latched and on the fresh status
  function automatic logic word_mem(input logic [7:0] s);
    return !s[ST_XTRQ_N] && (s[ST_MEMR] || (!s[ST_WO_N] && !s[ST_OUT]));
  endfunction

  // Cycle decode from the latched status word
  assign mem_rd = cyc_stat_out[ST_MEMR];
  assign mem_wr = !cyc_stat_out[ST_WO_N] && !cyc_stat_out[ST_OUT];
  assign io_out = !cyc_stat_out[ST_WO_N] && cyc_stat_out[ST_OUT];
  assign io_in = cyc_stat_out[ST_INP];
  assign inta = cyc_stat_out[ST_INTA];
  assign word = word_mem(cyc_stat_out);
  assign a = cyc_addr_q[MEM_AW-1:0];
  assign ev = {a[MEM_AW-1:1], 1'b0};
  assign od = {a[MEM_AW-1:1], 1'b1};
  assign da = f_data[MEM_AW+15:16];
  assign pend = ~vi2_q & ~vi_mask_in;

  // Bus inputs registered once on the system clock
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {sync_q, stval_q, dbin_q, wr_q, wr_old_q, phlda_q} <= 6'h00;
      stat_q <= 8'h00;
      addr_q <= 16'h0000;
      do_q <= 8'h00;
      di_q <= 8'h00;
    end else begin
      sync_q <= bus.sync;
      stval_q <= ~bus.stval_n;
      dbin_q <= bus.dbin;
      wr_q <= ~bus.wr_n;
      wr_old_q <= wr_q;
      phlda_q <= bus.phlda;
      stat_q <= bus.stat;
      addr_q <= bus.addr;
      do_q <= bus.do_b;
      di_q <= bus.di_b;
    end
  end

  // Vectored request pins come from outside, two flops first
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      vi1_q <= 8'hFF;
      vi2_q <= 8'hFF;
    end else begin
      vi1_q <= vi_n_in;
      vi2_q <= vi1_q;
    end
  end

  // Address and status taken only in the sync plus valid cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cyc_addr_q <= 16'h0000;
      cyc_stat_out <= 8'h00;
    end else if (sync_q && stval_q) begin
      cyc_addr_q <= addr_q;
      cyc_stat_out <= stat_q;
    end
  end

  // Write held until the buffer has room; set beats the clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pend_q <= 1'b0;
      pend_data_q <= '0;
    end else if (wr_q && !wr_old_q && (mem_wr || io_out)) begin
      pend_q <= 1'b1;
      pend_data_q <= {io_out, word, cyc_addr_q[7:0], di_q, do_q};
    end else if (f_rdy) begin
      pend_q <= 1'b0;
    end
  end

  sbc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .in_valid_in(pend_q),
    .in_data_in(pend_data_q),
    .in_ready_out(f_rdy),
    .out_valid_out(f_vld),
    .out_data_out(f_data),
    .out_ready_in(!drain_stall_in)
  );

  // Drain buffer into memory bytes or the I/O port
  always_ff @(posedge mclk_in) begin
    io_wr_valid_out <= 1'b0;
    if (srst_in) begin
      io_wr_addr_out <= 8'h00;
      io_wr_data_out <= 16'h0000;
    end else if (f_vld && !drain_stall_in) begin
      if (f_data[25]) begin
        io_wr_valid_out <= 1'b1;
        io_wr_addr_out <= f_data[23:16];
        io_wr_data_out <= {8'h00, f_data[7:0]};
      end else if (f_data[24]) begin
        mem_q[{da[MEM_AW-1:1], 1'b0}] <= f_data[7:0];
        mem_q[{da[MEM_AW-1:1], 1'b1}] <= f_data[15:8];
      end else begin
        mem_q[da] <= f_data[7:0];
      end
    end
  end

  // Read data driven while the registered read strobe stands, two edges behind the bus line
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_di_oe_q <= 1'b0;
      s_do_oe_q <= 1'b0;
      s_di_q <= 8'h00;
      s_do_q <= 8'h00;
    end else begin
      s_di_oe_q <= dbin_q && (mem_rd || io_in || inta);
      s_do_oe_q <= dbin_q && word && mem_rd;
      s_do_q <= mem_q[ev];
      if (inta) begin
        s_di_q <= VEC_BASE | {2'h0, sbc_prio(pend), 3'h0};
      end else if (io_in) begin
        s_di_q <= io_rdata_in;
      end else if (word) begin
        s_di_q <= mem_q[od];
      end else begin
        s_di_q <= mem_q[a];
      end
    end
  end

  // Open-collector answers and requests
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      {rdy_oe_q, int_oe_q, nmi_oe_q, sixtn_oe_q, hold_oe_q} <= 5'h00;
      dma_oe_q <= 4'h0;
      dsb_oe_q <= 4'h0;
    end else begin
      rdy_oe_q <= !f_rdy || pend_q;
      int_oe_q <= |pend;
      nmi_oe_q <= nmi_req_in;
      // Fresh status in the sync cycle, so the master sees it before the strobe ends
      sixtn_oe_q <= word_mem((sync_q && stval_q) ? stat_q : cyc_stat_out);
      hold_oe_q <= dma_req_in;
      dma_oe_q <= dma_req_in ? dma_prio_in : 4'h0;
      dsb_oe_q <= {4{dma_req_in && phlda_q}};
    end
  end

  assign bus.s_do = s_do_q;
  assign bus.s_di = s_di_q;
  assign bus.s_do_oe = s_do_oe_q;
  assign bus.s_di_oe = s_di_oe_q;
  assign bus.s_rdy_oe = rdy_oe_q;
  assign bus.s_int_oe = int_oe_q;
  assign bus.s_nmi_oe = nmi_oe_q;
  assign bus.s_sixtn_oe = sixtn_oe_q;
  assign bus.s_hold_oe = hold_oe_q;
  assign bus.s_dma_oe = dma_oe_q;
  assign bus.s_dsb_oe = dsb_oe_q;
endmodule

// ### verif/sbc_bus_assertions.sv
// Purpose: line checks between the two bus ends
// Assumes: one clock, reset high and synchronous
// Notes: watches resolved line levels only
module sbc_bus_assertions
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Lines
  input wire logic [15:0] addr,
  input wire logic [7:0] stat,
  input wire logic sync,
  input wire logic stval_n,
  input wire logic dbin,
  input wire logic wr_n,
  input wire logic phlda,
  input wire logic hold_n,
  input wire logic sixtn_n,
  input wire logic [3:0] dsb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Checks
  // ****
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  AST_STVAL: assert property (sync |-> !stval_n)
    else $error("stval missing");
  AST_SYNC: assert property (sync |=> !sync)
    else $error("sync too long");
  AST_DBIN: assert property ($rose(dbin) |-> $past(sync))
    else $error("dbin early");
  AST_WR: assert property (!wr_n |-> !stat[ST_WO_N])
    else $error("write status");
  AST_RD: assert property (dbin |-> stat[ST_WO_N])
    else $error("read status");
  AST_HOLD: assert property ($rose(phlda) |-> !hold_n && !sync)
    else $error("grant unasked");
  // Drivers take two edges to let go, so give the disables four
  AST_DSB: assert property ((dsb_n == 4'h0)[*4] |-> stat == BUS_IDLE && addr == 16'hFFFF)
    else $error("drivers on");
  AST_SIXTN: assert property ($fell(sixtn_n) |-> !stat[ST_XTRQ_N])
    else $error("sixtn unasked");
  // Main scenarios
  CV_WR: cover property (!wr_n);
  CV_HOLD: cover property (phlda);
  CV_WORD: cover property (!sixtn_n);
endmodule

// ### verif/tb.sv
// Purpose: end to end bench for both bus ends
// Assumes: 20 MHz clock, 3 cycles of reset
// Notes: inputs move on the falling edge
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbc_pkg::*;
  // ****
  // Ends and checker
  // ****
  logic mclk_in = 0, srst_in = 1, req_valid_in = 0, req_word_in = 0, int_en_in = 1;
  logic hold_en_in = 0, nmi_clr_in = 0, xrdy_in = 1, drain_stall_in = 0, nmi_req_in = 0;
  logic dma_req_in = 0, req_ready_out, rsp_valid_out, rsp_word_out, int_pend_out;
  logic nmi_flag_out, hold_ack_out, io_wr_valid_out;
  logic [15:0] req_addr_in = 0, req_wdata_in = 0, rsp_rdata_out, io_wr_data_out, a, d;
  logic [7:0] io_rdata_in = 0, vi_n_in = 8'hFF, vi_mask_in = 0, io_wr_addr_out, cyc_stat_out;
  logic [3:0] dma_prio_in = 0, dma_win_out;
  sbc_cmd_t req_cmd_in = CMD_MRD;
  int n_errors = 0, n_tests = 0, n_io = 0;
  sbc_bus_if bus ();
  sbc_master sbc_master_inst (.mclk_in, .srst_in, .req_valid_in, .req_cmd_in, .req_word_in,
    .req_addr_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .rsp_word_out,
    .int_en_in, .hold_en_in, .nmi_clr_in, .xrdy_in, .int_pend_out, .nmi_flag_out, .hold_ack_out,
    .dma_win_out, .bus);
  sbc_slave sbc_slave_inst (.mclk_in, .srst_in, .drain_stall_in, .io_rdata_in,
    .io_wr_valid_out, .io_wr_addr_out, .io_wr_data_out, .vi_n_in, .vi_mask_in, .nmi_req_in,
    .dma_req_in, .dma_prio_in, .cyc_stat_out, .bus);
  sbc_bus_assertions sbc_bus_assertions_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .addr(bus.addr), .stat(bus.stat), .sync(bus.sync), .stval_n(bus.stval_n), .dbin(bus.dbin),
    .wr_n(bus.wr_n), .phlda(bus.phlda), .hold_n(bus.hold_n), .sixtn_n(bus.sixtn_n),
    .dsb_n(bus.dsb_n));
  // 25 ns half period
  always #25 mclk_in = ~mclk_in;
  // Port write pulses, counted mid-cycle where they stand
  always @(negedge mclk_in) begin
    if (io_wr_valid_out) n_io++;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // Count and report one comparison
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One request; ready is registered, so valid is held for one edge only
  task automatic cyc(input sbc_cmd_t c, input logic w, input logic [15:0] ad, wd);
    int k;
    for (k = 0; req_ready_out !== 1'b1 && k < 300; k++) tick(1);
    req_cmd_in = c;
    req_word_in = w;
    req_addr_in = ad;
    req_wdata_in = wd;
    req_valid_in = 1;
    tick(1);
    req_valid_in = 0;
    for (; rsp_valid_out !== 1'b1 && k < 300; k++) tick(1);
    if (k == 300) n_errors++;
  endtask
  // Expected vector: lowest active unmasked line
  function automatic logic [15:0] vec(input logic [7:0] act);
    logic [2:0] i;
    i = 0;
    for (int k = 7; k >= 0; k--)
      if (act[k]) i = 3'(k);
    return {8'h00, VEC_BASE | {2'h0, i, 3'h0}};
  endfunction
  // Verdict, also reached from the watchdog
  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Run needs about 20 us; five times that means a hang
  initial begin
    #100us;
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h2E50));
    tick(3);
    srst_in = 0;
    // Byte round trips, top address first
    for (int i = 0; i < 4; i++) begin
      a = i ? 16'($urandom) & 16'h007F : 16'h007F;
      d = 16'($urandom);
      cyc(CMD_MWR, 0, a, d);
      tick(4);
      cyc(i[0] ? CMD_FETCH : CMD_MRD, 0, a, 0);
      chk("byte", rsp_rdata_out, {8'h00, d[7:0]});
    end
    // Word at an even address, high byte back alone
    a[0] = 0;
    cyc(CMD_MWR, 1, a, d);
    tick(4);
    cyc(CMD_MRD, 1, a, 0);
    chk("word", rsp_rdata_out, d);
    chk("wflag", 16'(rsp_word_out), 16'h1);
    cyc(CMD_MRD, 0, a | 16'h1, 0);
    chk("high", rsp_rdata_out, {8'h00, d[15:8]});
    // Word read straight after a byte cycle must still be acknowledged in time
    cyc(CMD_MRD, 1, a, 0);
    chk("word2", rsp_rdata_out, d);
    chk("wflag2", 16'(rsp_word_out), 16'h1);
    // Front panel stop holds the read strobe until released
    xrdy_in = 0;
    fork
      begin
        tick(12);
        chk("xstop", 16'(bus.dbin), 16'h1);
        xrdy_in = 1;
      end
    join_none
    cyc(CMD_MRD, 0, a | 16'h1, 0);
    chk("xrdy", rsp_rdata_out, {8'h00, d[15:8]});
    // Port write, port read and halt each finish one cycle
    io_rdata_in = 8'($urandom);
    cyc(CMD_OUT, 0, a, d);
    tick(4);
    chk("oport", {io_wr_addr_out, io_wr_data_out[7:0]}, {a[7:0], d[7:0]});
    chk("ohigh", {8'h00, io_wr_data_out[15:8]}, 16'h0000);
    chk("opulse", 16'(n_io), 16'h1);
    cyc(CMD_IN, 0, a, 0);
    chk("iport", rsp_rdata_out, {8'h00, io_rdata_in});
    cyc(CMD_HALT, 0, 0, 0);
    // Halt byte cycle: halt set, write and word request lines at their idle-high levels
    chk("halt", 16'(cyc_stat_out), 16'h00C4);
    // Stalled drain: buffer fills, later writes wait, all land
    drain_stall_in = 1;
    fork
      begin
        tick(90);
        drain_stall_in = 0;
      end
    join_none
    for (int i = 0; i < 10; i++) cyc(CMD_MWR, 0, 16'(i + 'h40), 16'(i * 'h25));
    tick(20);
    for (int i = 0; i < 10; i++) begin
      cyc(CMD_MRD, 0, 16'(i + 'h40), 0);
      chk("fifo", rsp_rdata_out, 16'(8'(i * 'h25)));
    end
    // Vectored requests with random masks; line 7 always stays open
    for (int i = 0; i < 3; i++) begin
      vi_n_in = 8'($urandom) & 8'h7F;
      vi_mask_in = 8'($urandom) & 8'h7F;
      tick(8);
      chk("int", 16'(int_pend_out), 16'h1);
      cyc(CMD_INTA, 0, 0, 0);
      chk("vec", rsp_rdata_out, vec(~vi_n_in & ~vi_mask_in));
    end
    // Masked INT, unmaskable NMI
    int_en_in = 0;
    nmi_req_in = 1;
    tick(8);
    nmi_req_in = 0;
    chk("imask", 16'(int_pend_out), 16'h0);
    chk("nmi", 16'(nmi_flag_out), 16'h1);
    nmi_clr_in = 1;
    tick(1);
    nmi_clr_in = 0;
    chk("nclr", 16'(nmi_flag_out), 16'h0);
    // Masked hold ignored, unmasked hold granted then released
    dma_prio_in = 4'($urandom) | 4'h1;
    dma_req_in = 1;
    tick(8);
    chk("prio", 16'(dma_win_out), 16'(dma_prio_in));
    chk("hmask", 16'(hold_ack_out), 16'h0);
    hold_en_in = 1;
    tick(8);
    chk("grant", 16'({hold_ack_out, req_ready_out}), 16'h2);
    dma_req_in = 0;
    tick(8);
    chk("free", 16'(hold_ack_out), 16'h0);
    results();
  end
endmodule
